// ==== cosync_pkg.sv ====
package cosync_pkg;
    // Object dictionary indices used as register addresses
    localparam logic [15:0] SYNC_ID_IDX = 16'h1005;
    localparam logic [15:0] SYNC_PERIOD_IDX = 16'h1006;
    localparam logic [15:0] ERR_REG_IDX = 16'h1001;
    localparam logic [15:0] ERR_FIELD_IDX = 16'h1003;
    localparam logic [15:0] EMCY_ID_IDX = 16'h1014;
    localparam logic [15:0] EMCY_MON_ADDR = 16'hE031;
    localparam logic [15:0] TPDO_TYPE_IDX = 16'h1800;
    localparam logic [15:0] TPDO_INHIBIT_IDX = 16'h1801;
    localparam logic [15:0] TPDO_TIMER_IDX = 16'h1802;
    localparam logic [15:0] RPDO_TYPE_IDX = 16'h1400;
    // Sub-indices of the PDO communication entries
    localparam logic [7:0] SUB_TYPE = 8'h02;
    localparam logic [7:0] SUB_INHIBIT = 8'h03;
    localparam logic [7:0] SUB_TIMER = 8'h05;
    // Field positions
    localparam int SYNC_GEN_BIT = 30;
    localparam int EMCY_OFF_BIT = 31;
    // Reset values
    localparam logic [31:0] SYNC_ID_RST = 32'h0000_0080;
    localparam logic [31:0] EMCY_ID_RST = 32'h8000_0080;
    localparam logic [10:0] SYNC_COB = 11'h080;
    localparam logic [10:0] EMCY_BASE = 11'h080;
    // Transmission type codes
    localparam logic [7:0] TT_ACYC = 8'h00;
    localparam logic [7:0] TT_CYC_MAX = 8'hF0;
    localparam logic [7:0] TT_ASYNC_A = 8'hFE;
    localparam logic [7:0] TT_ASYNC_B = 8'hFF;
    // Emergency error codes
    localparam logic [15:0] EC_USER = 16'hFF00;
    localparam logic [15:0] EC_COMM = 16'h8100;
    // Timing: period in us is in sync period object; inhibit unit 125 us
    localparam int CLK_MHZ = 25;
    localparam int INHIBIT_UNIT_US = 125;
    localparam int CYC_PER_US = CLK_MHZ;
    localparam int CYC_PER_INH = INHIBIT_UNIT_US * CLK_MHZ;
    localparam int CYC_PER_MS = 1000 * CLK_MHZ;
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_LOAD = 2'b01,
        CS_SEND = 2'b11
    } cosync_emst_t;
endpackage : cosync_pkg

// ==== cosync_tick.sv ====
`timescale 1ns/1ns
`default_nettype none
// Free running divider: one pulse every DIV cycles
module cosync_tick #(
    parameter int DIV = 25
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    logic [15:0] cnt_q; // Cycle counter
    always_ff @(posedge clk) begin
        if (rst || cnt_q == 16'(DIV - 1)) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    assign tick = (cnt_q == 16'(DIV - 1));
endmodule : cosync_tick
`default_nettype wire

// ==== cosync_core.sv ====
`timescale 1ns/1ns
`default_nettype none
module cosync_core
    import cosync_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] nodeId,
    // Object dictionary access
    input wire logic odWrite,
    input wire logic odRead,
    input wire logic [15:0] odIndex,
    input wire logic [7:0] odSub,
    input wire logic [31:0] odWdata,
    output logic [31:0] odRdata,
    // Received frames
    input wire logic rxValid,
    input wire logic [10:0] rxCobId,
    input wire logic [63:0] rxData,
    // Application side
    input wire logic tpdoChanged,
    output logic txPdoReq,
    output logic [63:0] appData,
    output logic appUpdate,
    input wire logic commFault,
    input wire logic userFault,
    input wire logic [31:0] userCode,
    // Frame transmitter
    output logic txValid,
    output logic [10:0] txCobId,
    output logic [63:0] txData,
    input wire logic txReady
);
    ////////////////////////////////////////////////////////////////////////////////
    // Object storage
    logic [31:0] syncId_q; // Sync identifier object
    logic [31:0] syncPeriod_q; // Sync period in microseconds
    logic [31:0] emcyId_q; // Emergency identifier object
    logic [7:0] errReg_q; // Error register
    logic [31:0] errField_q; // Latest predefined error entry
    logic [7:0] errCount_q; // Number of errors recorded
    logic [7:0] tType_q; // TPDO transmission type
    logic [15:0] inhibit_q; // TPDO inhibit time in 125 us units
    logic [15:0] evTimer_q; // TPDO event timer in ms
    logic [7:0] rType_q; // RPDO transmission type
    logic wrHit; // Write strobe gate
    assign wrHit = odWrite;
    // Writes to dictionary entries
    always_ff @(posedge clk) begin
        if (rst) begin
            syncId_q <= SYNC_ID_RST;
            syncPeriod_q <= 32'h0000_0000;
            emcyId_q <= EMCY_ID_RST;
            tType_q <= TT_ASYNC_B;
            inhibit_q <= 16'h0000;
            evTimer_q <= 16'h0000;
            rType_q <= TT_ASYNC_B;
        end else if (wrHit) begin
            case (odIndex)
                SYNC_ID_IDX: syncId_q <= odWdata;
                SYNC_PERIOD_IDX: syncPeriod_q <= odWdata;
                EMCY_ID_IDX: emcyId_q <= odWdata;
                TPDO_TYPE_IDX: begin
                    if (odSub == SUB_TYPE) begin
                        tType_q <= odWdata[7:0];
                    end else if (odSub == SUB_INHIBIT) begin
                        inhibit_q <= odWdata[15:0];
                    end else if (odSub == SUB_TIMER) begin
                        evTimer_q <= odWdata[15:0];
                    end
                end
                RPDO_TYPE_IDX: begin
                    if (odSub == SUB_TYPE) begin
                        rType_q <= odWdata[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Time bases
    logic usTick; // One microsecond
    logic inhTick; // One inhibit unit
    logic msTick; // One millisecond
    logic fire; // TPDO send now
    cosync_tick #(.DIV(CYC_PER_US)) uUs (.clk(clk), .rst(rst), .tick(usTick));
    // Inhibit and event bases restart at each send; free running they could cut a unit short
    cosync_tick #(.DIV(CYC_PER_INH)) uInh (.clk(clk), .rst(rst || fire), .tick(inhTick));
    cosync_tick #(.DIV(CYC_PER_MS)) uMs (.clk(clk), .rst(rst || fire), .tick(msTick));
    ////////////////////////////////////////////////////////////////////////////////
    // Sync generator and consumer
    logic genOn; // Local producer active
    logic [31:0] genCnt_q; // Microseconds since last generated sync
    logic genSync; // Generated sync this cycle
    logic rxSync; // Sync received from the network
    logic syncEv; // Any sync event
    logic genPend_q; // Generated sync awaiting the transmitter
    assign genOn = syncId_q[SYNC_GEN_BIT] && (syncPeriod_q != 32'h0000_0000);
    // Only consume when not producing, so one producer on the bus
    assign rxSync = rxValid && (rxCobId == SYNC_COB) && !genOn;
    assign genSync = genOn && usTick && (genCnt_q + 32'h1 >= syncPeriod_q);
    assign syncEv = rxSync || genSync;
    // Period counter
    always_ff @(posedge clk) begin
        if (rst || !genOn || genSync) begin
            genCnt_q <= 32'h0000_0000;
        end else if (usTick) begin
            genCnt_q <= genCnt_q + 32'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // RPDO delivery: held until sync or passed at once
    logic rpdoRx; // RPDO frame received
    logic rAsync; // Asynchronous receive type
    logic [63:0] rHold_q; // Held command
    logic rHeld_q; // Held data valid
    assign rpdoRx = rxValid && (rxCobId == (11'h200 + {4'h0, nodeId}));
    assign rAsync = (rType_q == TT_ASYNC_A) || (rType_q == TT_ASYNC_B);
    // Latch pending command for synchronous types
    always_ff @(posedge clk) begin
        if (rst) begin
            rHold_q <= 64'h0;
            rHeld_q <= 1'b0;
        end else if (rpdoRx && !rAsync && rType_q <= TT_CYC_MAX) begin
            rHold_q <= rxData;
            rHeld_q <= 1'b1;
        end else if (syncEv) begin
            rHeld_q <= 1'b0;
        end
    end
    // Deliver to application
    always_ff @(posedge clk) begin
        if (rst) begin
            appData <= 64'h0;
            appUpdate <= 1'b0;
        end else if (rpdoRx && rAsync) begin
            appData <= rxData;
            appUpdate <= 1'b1;
        end else if (syncEv && rHeld_q) begin
            appData <= rHold_q;
            appUpdate <= 1'b1;
        end else begin
            appUpdate <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // TPDO trigger
    logic tAsync; // Asynchronous transmit type
    logic [7:0] syncCnt_q; // Syncs since last send
    logic changed_q; // Mapped data changed since last send
    logic [15:0] inhCnt_q; // Inhibit units remaining
    logic [15:0] evCnt_q; // Event timer ms elapsed
    logic want; // Trigger condition
    assign tAsync = (tType_q == TT_ASYNC_A) || (tType_q == TT_ASYNC_B);
    always_comb begin
        want = 1'b0;
        if (tType_q == TT_ACYC) begin
            want = syncEv && (changed_q || tpdoChanged);
        end else if (tType_q <= TT_CYC_MAX) begin
            // Nine bits so a saturated count never wraps to zero
            want = syncEv && ({1'b0, syncCnt_q} + 9'h001 >= {1'b0, tType_q});
        end else if (tAsync) begin
            want = tpdoChanged || changed_q ||
                ((evTimer_q != 16'h0) && (evCnt_q >= evTimer_q));
        end
    end
    assign fire = want && (inhCnt_q == 16'h0);
    assign txPdoReq = fire;
    // Change flag; a change seen in the send cycle already goes out in that frame
    always_ff @(posedge clk) begin
        if (rst) begin
            changed_q <= 1'b0;
        end else if (tpdoChanged && !fire) begin
            changed_q <= 1'b1;
        end else if (fire) begin
            changed_q <= 1'b0;
        end
    end
    // Sync counter per TPDO
    always_ff @(posedge clk) begin
        if (rst || fire) begin
            syncCnt_q <= 8'h00;
        end else if (syncEv && syncCnt_q != 8'hFF) begin
            syncCnt_q <= syncCnt_q + 8'h01;
        end
    end
    // Inhibit and event timers
    always_ff @(posedge clk) begin
        if (rst) begin
            inhCnt_q <= 16'h0;
            evCnt_q <= 16'h0;
        end else begin
            if (fire) begin
                inhCnt_q <= inhibit_q;
            end else if (inhTick && inhCnt_q != 16'h0) begin
                inhCnt_q <= inhCnt_q - 16'h1;
            end
            if (fire || !tAsync) begin
                evCnt_q <= 16'h0;
            end else if (msTick && evCnt_q != 16'hFFFF) begin
                evCnt_q <= evCnt_q + 16'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Error register and error field, regardless of emergency enable
    logic fault; // Any fault
    logic [15:0] errCode; // Code for this fault
    assign fault = commFault || userFault;
    assign errCode = userFault ? EC_USER : EC_COMM;
    always_ff @(posedge clk) begin
        if (rst) begin
            errReg_q <= 8'h00;
            errField_q <= 32'h0;
            errCount_q <= 8'h00;
        end else if (fault) begin
            errReg_q <= {errReg_q[7:5], commFault, errReg_q[3:1], 1'b1};
            errField_q <= {userFault ? userCode[15:0] : 16'h0000, errCode};
            if (errCount_q != 8'hFF) begin
                errCount_q <= errCount_q + 8'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Emergency and sync frame sender; foreign emergency frames never decoded
    cosync_emst_t st_q; // Sender state
    logic sendSync_q; // Frame in flight is a sync
    logic emcyOn; // Emergency frames enabled
    logic emcyActive_q; // Emergency pending or sent since reset
    logic emcyPend_q; // Fault waiting for send
    logic [63:0] emcyPay_q; // Emergency payload
    assign emcyOn = !emcyId_q[EMCY_OFF_BIT];
    always_ff @(posedge clk) begin
        if (rst) begin
            emcyPend_q <= 1'b0;
            emcyPay_q <= 64'h0;
            emcyActive_q <= 1'b0;
        end else if (fault && emcyOn) begin
            emcyPend_q <= 1'b1;
            emcyActive_q <= 1'b1;
            // Bytes 0-1 code low byte first, 2 error register, 3 reserved, 4-7 aux
            emcyPay_q <= {userFault ? userCode : 32'h0, 8'h00,
                errReg_q | 8'h01, errCode};
        end else if (st_q == CS_SEND && txReady && !sendSync_q) begin
            emcyPend_q <= 1'b0;
        end
    end
    // Generated sync waits for the transmitter
    always_ff @(posedge clk) begin
        if (rst) begin
            genPend_q <= 1'b0;
        end else if (genSync) begin
            genPend_q <= 1'b1;
        end else if (st_q == CS_SEND && txReady && sendSync_q) begin
            genPend_q <= 1'b0;
        end
    end
    // Frame sender state machine; sync has priority
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= CS_IDLE;
            sendSync_q <= 1'b0;
            txCobId <= 11'h0;
            txData <= 64'h0;
        end else begin
            case (st_q)
                CS_IDLE: if (genPend_q || emcyPend_q) begin
                    st_q <= CS_LOAD;
                end
                CS_LOAD: begin
                    st_q <= CS_SEND;
                    // Remember the kind, a sync raised mid-send must not clear an emergency
                    sendSync_q <= genPend_q;
                    if (genPend_q) begin
                        txCobId <= SYNC_COB;
                        txData <= 64'h0;
                    end else begin
                        txCobId <= EMCY_BASE + {4'h0, nodeId};
                        txData <= {emcyPay_q[63:24], errReg_q, emcyPay_q[15:0]};
                    end
                end
                CS_SEND: if (txReady) begin
                    st_q <= CS_IDLE;
                end
                default: st_q <= CS_IDLE;
            endcase
        end
    end
    assign txValid = (st_q == CS_SEND);
    ////////////////////////////////////////////////////////////////////////////////
    // Read back
    always_ff @(posedge clk) begin
        if (rst) begin
            odRdata <= 32'h0;
        end else if (odRead) begin
            case (odIndex)
                SYNC_ID_IDX: odRdata <= syncId_q;
                SYNC_PERIOD_IDX: odRdata <= syncPeriod_q;
                EMCY_ID_IDX: odRdata <= {emcyId_q[31:11], EMCY_BASE + {4'h0, nodeId}};
                ERR_REG_IDX: odRdata <= {24'h0, errReg_q};
                ERR_FIELD_IDX: odRdata <= (odSub == 8'h00) ? {24'h0, errCount_q}
                    : errField_q;
                EMCY_MON_ADDR: odRdata <= {31'h0, emcyActive_q};
                default: odRdata <= 32'h0;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    a_inhibit_gap: assert property (@(posedge clk) disable iff (rst)
        fire && inhibit_q != 16'h0 |=> !fire [*8]) else $error("inhibit violated");
    a_sync_type0: assert property (@(posedge clk) disable iff (rst)
        fire && tType_q == TT_ACYC |-> syncEv) else $error("type 0 sent without sync");
    a_async_rpdo: assert property (@(posedge clk) disable iff (rst)
        rpdoRx && rAsync |=> appUpdate && appData == $past(rxData))
        else $error("async rpdo not passed");
    a_sync_rpdo: assert property (@(posedge clk) disable iff (rst)
        appUpdate && !$past(rpdoRx) |-> $past(syncEv)) else $error("held data leaked");
    a_emcy_off: assert property (@(posedge clk) disable iff (rst)
        fault && !emcyOn && !emcyPend_q && !genPend_q |=> !emcyPend_q)
        else $error("emergency when disabled");
    a_err_update: assert property (@(posedge clk) disable iff (rst)
        fault |=> errReg_q[0]) else $error("error register not set");
    a_user_code: assert property (@(posedge clk) disable iff (rst)
        userFault && emcyOn |=> emcyPay_q[15:0] == EC_USER) else $error("user code wrong");
    a_sync_gen: assert property (@(posedge clk) disable iff (rst)
        genSync |-> syncId_q[SYNC_GEN_BIT]) else $error("sync without enable");
    a_cyc_count: assert property (@(posedge clk) disable iff (rst)
        fire |=> syncCnt_q == 8'h00) else $error("count not reset");
    c_emcy_sent: cover property (@(posedge clk) txValid && txReady && txCobId != SYNC_COB);
    c_sync_sent: cover property (@(posedge clk) txValid && txReady && txCobId == SYNC_COB);
    c_cyc_fire: cover property (@(posedge clk) fire && tType_q == 8'h03);
endmodule : cosync_core
`default_nettype wire

// ==== cosync_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side of the bus: the network master and the other nodes
module cosync_master_model (
    input wire logic clk,
    input wire logic txValid,
    output logic txReady,
    output logic rxValid,
    output logic [10:0] rxCobId,
    output logic [63:0] rxData
);
    int stall = 0; // Acknowledge delay in cycles, zero answers promptly
    int waitCnt = 0; // Cycles the current frame has waited
    // Idle bus at time zero
    initial begin
        txReady = 1'b0;
        rxValid = 1'b0;
        rxCobId = 11'h7FF;
        rxData = 64'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge a waiting frame once the stall has run out, for one cycle only
    always @(posedge clk) begin
        if (txValid === 1'b1 && txReady === 1'b0 && waitCnt >= stall) begin
            txReady <= 1'b1;
            waitCnt <= 0;
        end else begin
            txReady <= 1'b0;
            waitCnt <= (txValid === 1'b1 && txReady === 1'b0) ? waitCnt + 1 : 0;
        end
    end
    // One frame; fields are inverted afterwards so stale values are never trusted
    task automatic sendFrame(input logic [10:0] cob, input logic [63:0] data);
        @(posedge clk);
        rxValid <= 1'b1;
        rxCobId <= cob;
        rxData <= data;
        @(posedge clk);
        rxValid <= 1'b0;
        rxCobId <= ~cob;
        rxData <= ~data;
    endtask : sendFrame
endmodule : cosync_master_model
`default_nettype wire

// ==== test_canopen_sync_emcy_pdo_trigger.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_canopen_sync_emcy_pdo_trigger;
    import cosync_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] nodeId = 7'h05; // Node address used throughout
    logic odWrite = 1'b0;
    logic odRead = 1'b0;
    logic [15:0] odIndex = 16'h0000;
    logic [7:0] odSub = 8'h00;
    logic [31:0] odWdata = 32'h0000_0000;
    logic [31:0] odRdata;
    logic tpdoChanged = 1'b0;
    logic commFault = 1'b0;
    logic userFault = 1'b0;
    logic [31:0] userCode = 32'h0000_0000;
    logic rxValid, txReady, txPdoReq, appUpdate, txValid;
    logic [10:0] rxCobId, txCobId, lastCob;
    logic [63:0] rxData, appData, txData, lastTx;
    int err_count = 0;
    int samples_checked = 0;
    int reqCnt = 0, appCnt = 0, txCnt = 0, cyc = 0, lastAt = 0; // Event tallies
    always #20 clk = ~clk;
    cosync_core uut (.clk(clk), .rst(rst), .nodeId(nodeId), .odWrite(odWrite),
        .odRead(odRead), .odIndex(odIndex), .odSub(odSub), .odWdata(odWdata),
        .odRdata(odRdata), .rxValid(rxValid), .rxCobId(rxCobId), .rxData(rxData),
        .tpdoChanged(tpdoChanged), .txPdoReq(txPdoReq), .appData(appData),
        .appUpdate(appUpdate), .commFault(commFault), .userFault(userFault),
        .userCode(userCode), .txValid(txValid), .txCobId(txCobId), .txData(txData),
        .txReady(txReady));
    cosync_master_model mdl (.clk(clk), .txValid(txValid), .txReady(txReady),
        .rxValid(rxValid), .rxCobId(rxCobId), .rxData(rxData));
    ////////////////////////////////////////////////////////////////////////////
    // Tally pulses and accepted frames; single-cycle outputs are seen in their cycle
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (txPdoReq === 1'b1) reqCnt <= reqCnt + 1;
        if (appUpdate === 1'b1) appCnt <= appCnt + 1;
        if (txValid === 1'b1 && txReady === 1'b1) begin
            txCnt <= txCnt + 1;
            lastCob <= txCobId;
            lastTx <= txData;
            lastAt <= cyc;
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t ns: %s", $time, msg);
        end
    endtask : chk
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    task automatic odWr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
        @(posedge clk);
        odWrite <= 1'b1;
        odIndex <= idx;
        odSub <= sub;
        odWdata <= d;
        @(posedge clk);
        odWrite <= 1'b0;
    endtask : odWr
    // Extra edge before sampling: the read data stands until the next read
    task automatic odRd(input logic [15:0] idx, input logic [7:0] sub, output logic [31:0] d);
        @(posedge clk);
        odRead <= 1'b1;
        odIndex <= idx;
        odSub <= sub;
        @(posedge clk);
        odRead <= 1'b0;
        cycles(1);
        d = odRdata;
    endtask : odRd
    task automatic chgPulse;
        @(posedge clk);
        tpdoChanged <= 1'b1;
        @(posedge clk);
        tpdoChanged <= 1'b0;
    endtask : chgPulse
    task automatic faultPulse(input logic user);
        @(posedge clk);
        userFault <= user;
        commFault <= ~user;
        @(posedge clk);
        userFault <= 1'b0;
        commFault <= 1'b0;
    endtask : faultPulse
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] d;
        odRd(SYNC_ID_IDX, 8'h00, d);
        chk(d, SYNC_ID_RST, "sync identifier reset");
        odRd(EMCY_ID_IDX, 8'h00, d);
        chk(d, EMCY_ID_RST + 32'(nodeId), "emergency identifier reset");
        odWr(16'h2345, 8'h00, 32'hA5A5_A5A5);
        odRd(16'h2345, 8'h00, d);
        chk(d, 32'h0000_0000, "unmapped index");
        $display("t_regs done");
    endtask : t_regs
    // Sync-driven transmit types; nothing has counted syncs before this test
    task automatic t_tpdo;
        int n;
        odWr(TPDO_TYPE_IDX, SUB_INHIBIT, 32'h0000_0000);
        odWr(TPDO_TYPE_IDX, SUB_TYPE, 32'h0000_0003);
        n = reqCnt;
        for (int i = 1; i <= 6; i++) begin
            mdl.sendFrame(SYNC_COB, 64'h0);
            cycles(3);
            chk(64'(reqCnt - n), 64'(i / 3), "cyclic transmit count");
        end
        odWr(TPDO_TYPE_IDX, SUB_TYPE, 32'h0000_0000);
        n = reqCnt;
        mdl.sendFrame(SYNC_COB, 64'h0);
        cycles(3);
        chk(64'(reqCnt - n), 64'h0, "acyclic without change");
        chgPulse();
        cycles(4);
        chk(64'(reqCnt - n), 64'h0, "acyclic waits for sync");
        mdl.sendFrame(SYNC_COB, 64'h0);
        cycles(3);
        chk(64'(reqCnt - n), 64'h1, "acyclic on change and sync");
        $display("t_tpdo done");
    endtask : t_tpdo
    task automatic t_async;
        int n;
        odWr(TPDO_TYPE_IDX, SUB_TYPE, 32'h0000_00FE);
        odWr(TPDO_TYPE_IDX, SUB_INHIBIT, 32'h0000_0002);
        n = reqCnt;
        chgPulse();
        cycles(4);
        chk(64'(reqCnt - n), 64'h1, "change sends at once");
        chgPulse();
        cycles(2 * CYC_PER_INH - 20);
        chk(64'(reqCnt - n), 64'h1, "inhibit spacing");
        odWr(TPDO_TYPE_IDX, SUB_TYPE, 32'h0000_00FF);
        odWr(TPDO_TYPE_IDX, SUB_INHIBIT, 32'h0000_0000);
        cycles(400);
        n = reqCnt;
        odWr(TPDO_TYPE_IDX, SUB_TIMER, 32'h0000_0001);
        cycles(CYC_PER_MS + 10);
        chk(64'(reqCnt - n), 64'h1, "event timer expiry");
        odWr(TPDO_TYPE_IDX, SUB_TIMER, 32'h0000_0000);
        $display("t_async done");
    endtask : t_async
    task automatic t_rpdo;
        int n;
        logic [10:0] cob;
        cob = 11'h200 + 11'(nodeId);
        odWr(RPDO_TYPE_IDX, SUB_TYPE, 32'h0000_0001);
        n = appCnt;
        mdl.sendFrame(cob, 64'h8877_6655_4433_2211);
        cycles(6);
        chk(64'(appCnt - n), 64'h0, "data held until sync");
        mdl.sendFrame(SYNC_COB, 64'h0);
        cycles(3);
        chk(64'(appCnt - n), 64'h1, "data released on sync");
        chk(appData, 64'h8877_6655_4433_2211, "released data");
        odWr(RPDO_TYPE_IDX, SUB_TYPE, 32'h0000_00FF);
        n = appCnt;
        mdl.sendFrame(cob, 64'h0123_4567_89AB_CDEF);
        cycles(3);
        chk(64'(appCnt - n), 64'h1, "immediate delivery");
        chk(appData, 64'h0123_4567_89AB_CDEF, "immediate data");
        $display("t_rpdo done");
    endtask : t_rpdo
    task automatic t_emcy;
        logic [31:0] d;
        int t;
        t = txCnt;
        userCode <= 32'hCAFE_0123;
        faultPulse(1'b1);
        cycles(10);
        chk(64'(txCnt - t), 64'h0, "no emergency while disabled");
        odRd(ERR_REG_IDX, 8'h00, d);
        chk(d[0], 1'b1, "error register after fault");
        odRd(ERR_FIELD_IDX, 8'h01, d);
        chk(d[15:0], EC_USER, "error field after fault");
        odWr(EMCY_ID_IDX, 8'h00, {21'h0, EMCY_BASE} + 32'(nodeId));
        mdl.stall = 5;
        faultPulse(1'b1);
        cycles(20);
        chk(64'(txCnt - t), 64'h1, "user emergency sent");
        chk(lastCob, EMCY_BASE + 11'(nodeId), "emergency identifier");
        odRd(ERR_REG_IDX, 8'h00, d);
        chk(lastTx, {32'hCAFE_0123, 8'h00, d[7:0], EC_USER}, "user frame");
        faultPulse(1'b0);
        cycles(20);
        odRd(ERR_REG_IDX, 8'h00, d);
        chk(lastTx, {32'h0, 8'h00, d[7:0], EC_COMM}, "comm frame");
        mdl.sendFrame(EMCY_BASE + 11'h001, 64'h0000_0000_0000_FF00);
        cycles(10);
        chk(64'(txCnt - t), 64'h2, "foreign emergency ignored");
        odRd(EMCY_MON_ADDR, 8'h00, d);
        chk(d[0], 1'b1, "emergency monitor");
        mdl.stall = 0;
        $display("t_emcy done");
    endtask : t_emcy
    task automatic t_syncgen;
        int t, at;
        odWr(SYNC_PERIOD_IDX, 8'h00, 32'h0000_0014);
        t = txCnt;
        odWr(SYNC_ID_IDX, 8'h00, SYNC_ID_RST | 32'h4000_0000);
        for (int k = 0; k < 700 && txCnt < t + 1; k++) cycles(1);
        at = lastAt;
        for (int k = 0; k < 700 && txCnt < t + 2; k++) cycles(1);
        chk(lastCob, SYNC_COB, "produced sync identifier");
        chk(lastTx, 64'h0, "produced sync carries no data");
        chk(64'(lastAt - at), 64'(20 * CYC_PER_US), "sync period");
        odWr(SYNC_PERIOD_IDX, 8'h00, 32'h0000_0000);
        cycles(10);
        t = txCnt;
        cycles(700);
        chk(64'(txCnt - t), 64'h0, "zero period silent");
        odWr(SYNC_PERIOD_IDX, 8'h00, 32'h0000_0014);
        odWr(SYNC_ID_IDX, 8'h00, SYNC_ID_RST);
        cycles(10);
        t = txCnt;
        cycles(700);
        chk(64'(txCnt - t), 64'h0, "generator off is consumer only");
        $display("t_syncgen done");
    endtask : t_syncgen
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    // Main sequence, run after the reset span
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_tpdo();
        t_async();
        t_rpdo();
        t_emcy();
        t_syncgen();
        wrap_up();
    end
    // Tests need about 34000 cycles; a hang is cut off well beyond that
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule : test_canopen_sync_emcy_pdo_trigger
`default_nettype wire
